//--- hdl/auxco_out.sv
/*
 Auxiliary code output: M, S, T and second-code words with strobes and a
 conventional or level-toggle completion handshake toward the machine-side
 controller. Assumes all inputs synchronous to sys_clk, one request per block.
*/
`timescale 1ns/10ps
module auxco_out
    import auxco_pkg::*;
#(
    parameter int CODE_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire auxco_req_t req,
    input wire auxco_lim_t [AUXCO_NFN-1:0] limits,
    input wire logic high_speed_sel,
    input wire auxco_if_t if_variant,
    input wire logic [5:0] axis_letter_used,
    input wire logic operation_done_in,
    input wire logic [AUXCO_NFN-1:0] fn_done_in,
    output logic req_ready,
    output logic req_reject,
    output logic [CODE_W-1:0] misc_code,
    output logic [CODE_W-1:0] spindle_code,
    output logic [CODE_W-1:0] tool_code,
    output logic [CODE_W-1:0] second_code,
    output logic misc_code_strobe,
    output logic [AUXCO_NFN-1:0] fn_strobe,
    output auxco_mdec_t misc_decode,
    output logic [AUXCO_NFN-1:0] fn_busy,
    output logic high_speed_active
);
    // Logic assumes full-width code words; refuse anything else at elaboration
    if (CODE_W != AUXCO_CODE_W) begin : g_bad_width
        $error("auxco_out: CODE_W must be 32");
    end

    // Limit check: digit count and sign, returns 1 when acceptable
    function automatic logic lim_ok(input auxco_req_t r, input auxco_lim_t l);
        lim_ok = (r.digits <= l.max_digits) && (r.digits <= 4'h8)
            && (!r.neg || l.allow_neg) && (r.mag <= AUXCO_MAX_MAG);
    endfunction

    // Signed word from sign and magnitude
    function automatic logic [31:0] to_word(input auxco_req_t r);
        to_word = r.neg ? (32'h0000_0000 - r.mag) : r.mag;
    endfunction

    // Handshake state, words, strobes
    auxco_hs_t hs [AUXCO_NFN];
    auxco_hs_t next_hs [AUXCO_NFN];
    logic [CODE_W-1:0] word [AUXCO_NFN];
    logic [CODE_W-1:0] next_word [AUXCO_NFN];
    logic [AUXCO_NFN-1:0] stb;
    logic [AUXCO_NFN-1:0] next_stb;
    auxco_mdec_t next_mdec;
    logic next_ready;
    logic next_reject;
    logic hs_mode;
    logic [AUXCO_NFN-1:0] busy_now;
    logic [AUXCO_NFN-1:0] next_busy;
    // Shared done input, previous sample for edge detection
    logic done_prev;

    // High-speed only honoured on the base interface
    // base interface only
    assign hs_mode = high_speed_sel && (if_variant == AUXCO_IF_BASE);

    // Next-state computation for all functions
    always_comb begin
        auxco_req_t r;
        logic [31:0] w;
        logic accept;
        logic special;
        logic letter_bad;
        r = req;
        w = to_word(req);
        next_mdec = misc_decode;
        next_stb = stb;
        next_reject = 1'b0;
        accept = 1'b0;
        special = (r.fn == 2'(AUXCO_FN_M)) && !r.neg
            && ((r.mag == AUXCO_M_SUB_CALL) || (r.mag == AUXCO_M_SUB_RET));
        letter_bad = (r.fn == 2'(AUXCO_FN_B))
            && ((r.letter > AUXCO_LTR_W) || axis_letter_used[r.letter]);
        for (int i = 0; i < AUXCO_NFN; i++) begin
            next_hs[i] = hs[i];
            next_word[i] = word[i];
            busy_now[i] = (hs[i] != AUXCO_IDLE);
        end
        // Completion per function
        // shared or per-function done
        for (int i = 0; i < AUXCO_NFN; i++) begin
            case (hs[i])
                AUXCO_IDLE: begin
                end
                AUXCO_WAIT_RISE: begin
                    if (operation_done_in && !done_prev) begin
                        next_hs[i] = AUXCO_WAIT_FALL;
                    end
                end
                AUXCO_WAIT_FALL: begin
                    if (!operation_done_in && done_prev) begin
                        next_hs[i] = AUXCO_IDLE;
                        next_stb[i] = 1'b0;
                    end
                end
                AUXCO_WAIT_LEVEL: begin
                    if (fn_done_in[i] == stb[i]) begin
                        next_hs[i] = AUXCO_IDLE;
                    end
                end
                default: next_hs[i] = AUXCO_IDLE;
            endcase
        end
        // New request; only one code per block is presented at a time
        // one code per block
        if (r.valid) begin
            if (!lim_ok(r, limits[r.fn]) || letter_bad) begin
                next_reject = 1'b1;
            end else if (special) begin
                accept = 1'b0;
            end else if (!busy_now[r.fn]) begin
                accept = 1'b1;
            end
        end
        if (accept) begin
            next_word[r.fn] = w;
            if (hs_mode) begin
                next_stb[r.fn] = ~stb[r.fn];
                next_hs[r.fn] = AUXCO_WAIT_LEVEL;
            end else begin
                next_stb[r.fn] = 1'b1;
                next_hs[r.fn] = AUXCO_WAIT_RISE;
            end
            if (r.fn == 2'(AUXCO_FN_M)) begin
                next_mdec.stop = (w == AUXCO_M_STOP);
                next_mdec.opt_stop = (w == AUXCO_M_OPT_STOP);
                next_mdec.end_prog = (w == AUXCO_M_END);
                next_mdec.end_rwd = (w == AUXCO_M_END_RWD);
            end
        end
        for (int i = 0; i < AUXCO_NFN; i++) begin
            next_busy[i] = (next_hs[i] != AUXCO_IDLE);
        end
        // Ready when no request is stalled this cycle
        next_ready = !(r.valid && !next_reject && !special && busy_now[r.fn]);
    end

    // Registers only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < AUXCO_NFN; i++) begin
                hs[i] <= AUXCO_IDLE;
                word[i] <= AUXCO_CODE_RST;
            end
            stb <= '0;
            done_prev <= 1'b0;
            misc_decode <= '0;
            req_ready <= 1'b1;
            req_reject <= 1'b0;
            fn_busy <= '0;
            high_speed_active <= 1'b0;
        end else begin
            for (int i = 0; i < AUXCO_NFN; i++) begin
                hs[i] <= next_hs[i];
                word[i] <= next_word[i];
            end
            stb <= next_stb;
            done_prev <= operation_done_in;
            misc_decode <= next_mdec;
            req_ready <= next_ready;
            req_reject <= next_reject;
            fn_busy <= next_busy;
            high_speed_active <= hs_mode;
        end
    end

    // Outputs straight from registers
    assign misc_code = word[AUXCO_FN_M];
    assign spindle_code = word[AUXCO_FN_S];
    assign tool_code = word[AUXCO_FN_T];
    assign second_code = word[AUXCO_FN_B];
    assign fn_strobe = stb;
    assign misc_code_strobe = stb[AUXCO_FN_M];

    // Assertions
    property p_toggle;
        @(posedge sys_clk) disable iff (rst)
        (req.valid && req.fn == 2'(AUXCO_FN_T) && hs[AUXCO_FN_T] == AUXCO_IDLE && hs_mode
            && lim_ok(req, limits[AUXCO_FN_T]))
        |=> (stb[AUXCO_FN_T] != $past(stb[AUXCO_FN_T]));
    endproperty
    a_toggle: assert property (p_toggle) else $error("strobe did not toggle");
    property p_level_done;
        @(posedge sys_clk) disable iff (rst)
        (hs[AUXCO_FN_T] == AUXCO_WAIT_LEVEL && fn_done_in[AUXCO_FN_T] == stb[AUXCO_FN_T])
        |=> hs[AUXCO_FN_T] == AUXCO_IDLE;
    endproperty
    a_level_done: assert property (p_level_done) else $error("level done missed");
    // Conventional: no completion without a fall of the shared done
    property p_conv_fall;
        @(posedge sys_clk) disable iff (rst)
        (hs[AUXCO_FN_M] == AUXCO_WAIT_FALL && !(done_prev && !operation_done_in))
        |=> hs[AUXCO_FN_M] == AUXCO_WAIT_FALL;
    endproperty
    a_conv_fall: assert property (p_conv_fall) else $error("done without fall");
    property p_hold;
        @(posedge sys_clk) disable iff (rst)
        !(req.valid && req.fn == 2'(AUXCO_FN_M)) |=> $stable(misc_code);
    endproperty
    a_hold: assert property (p_hold) else $error("M word changed");
    property p_sub;
        @(posedge sys_clk) disable iff (rst)
        (req.valid && req.fn == 2'(AUXCO_FN_M) && !req.neg && req.mag == AUXCO_M_SUB_CALL)
        |=> $stable(misc_code) && $stable(misc_code_strobe);
    endproperty
    a_sub: assert property (p_sub) else $error("subprogram code output");
    property p_legacy;
        @(posedge sys_clk) disable iff (rst)
        (if_variant != AUXCO_IF_BASE) |=> !high_speed_active;
    endproperty
    a_legacy: assert property (p_legacy) else $error("high-speed on legacy");
    property p_busy;
        @(posedge sys_clk) disable iff (rst)
        (fn_busy[AUXCO_FN_M] && hs[AUXCO_FN_M] != AUXCO_IDLE && req.valid
            && req.fn == 2'(AUXCO_FN_M)) |=> $stable(misc_code) && !req_ready;
    endproperty
    a_busy: assert property (p_busy) else $error("overran busy function");
    property p_neg;
        @(posedge sys_clk) disable iff (rst)
        (req.valid && req.neg && !limits[req.fn].allow_neg) |=> req_reject;
    endproperty
    a_neg: assert property (p_neg) else $error("sign not refused");
    // Conventional: waiting for the rise ignores everything but a rise
    property p_rise_first;
        @(posedge sys_clk) disable iff (rst)
        (hs[AUXCO_FN_M] == AUXCO_WAIT_RISE && !(operation_done_in && !done_prev))
        |=> hs[AUXCO_FN_M] == AUXCO_WAIT_RISE;
    endproperty
    a_rise_first: assert property (p_rise_first) else $error("done without rise");
    // Strobe and busy drop on the cycle after the fall
    property p_conv_clear;
        @(posedge sys_clk) disable iff (rst)
        (hs[AUXCO_FN_M] == AUXCO_WAIT_FALL && done_prev && !operation_done_in)
        |=> !misc_code_strobe && !fn_busy[AUXCO_FN_M];
    endproperty
    a_conv_clear: assert property (p_conv_clear) else $error("strobe not cleared");
    // Decoded rewind discrete agrees with the word
    property p_decode;
        @(posedge sys_clk) disable iff (rst)
        misc_decode.end_rwd |-> misc_code == AUXCO_M_END_RWD;
    endproperty
    a_decode: assert property (p_decode) else $error("decode disagrees with word");
    // Negative accepted M code comes out with the sign bit set
    property p_neg_word;
        @(posedge sys_clk) disable iff (rst)
        (req.valid && req.fn == 2'(AUXCO_FN_M) && req.neg && req.mag != 32'h0000_0000
            && hs[AUXCO_FN_M] == AUXCO_IDLE && lim_ok(req, limits[AUXCO_FN_M]))
        |=> misc_code[CODE_W-1];
    endproperty
    a_neg_word: assert property (p_neg_word) else $error("sign bit missing");
    // A refused request leaves every word alone
    property p_rej_hold;
        @(posedge sys_clk) disable iff (rst)
        req_reject |-> $stable(misc_code) && $stable(spindle_code) && $stable(tool_code)
            && $stable(second_code);
    endproperty
    a_rej_hold: assert property (p_rej_hold) else $error("refused code stored");
    // Cover points for the main scenarios
    c_hs: cover property (@(posedge sys_clk) disable iff (rst)
        hs[AUXCO_FN_T] == AUXCO_WAIT_LEVEL ##1 hs[AUXCO_FN_T] == AUXCO_IDLE);
    c_conv: cover property (@(posedge sys_clk) disable iff (rst) hs[0] == AUXCO_WAIT_FALL ##1
        hs[0] == AUXCO_IDLE);
    c_rej: cover property (@(posedge sys_clk) disable iff (rst) req_reject);
    c_stall: cover property (@(posedge sys_clk) disable iff (rst) !req_ready);
endmodule

//--- shared/auxco_pkg.sv
/*
 Package for the auxiliary code output block: function indices, handshake
 states, carrier structs and constants. Assumes a single 10 MHz system clock.
*/
package auxco_pkg;
    // Function indices
    localparam int AUXCO_FN_M = 0;
    localparam int AUXCO_FN_S = 1;
    localparam int AUXCO_FN_T = 2;
    localparam int AUXCO_FN_B = 3;
    localparam int AUXCO_NFN = 4;
    // Code word width
    localparam int AUXCO_CODE_W = 32;
    // Largest magnitude for eight decimal digits
    localparam logic [31:0] AUXCO_MAX_MAG = 32'h05F5_E0FF;
    // Special miscellaneous code values
    localparam logic [31:0] AUXCO_M_STOP = 32'h0000_0000;
    localparam logic [31:0] AUXCO_M_OPT_STOP = 32'h0000_0001;
    localparam logic [31:0] AUXCO_M_END = 32'h0000_0002;
    localparam logic [31:0] AUXCO_M_END_RWD = 32'h0000_001E;
    localparam logic [31:0] AUXCO_M_SUB_CALL = 32'h0000_0062;
    localparam logic [31:0] AUXCO_M_SUB_RET = 32'h0000_0063;
    // Second code address letters
    localparam logic [2:0] AUXCO_LTR_B = 3'h0;
    localparam logic [2:0] AUXCO_LTR_A = 3'h1;
    localparam logic [2:0] AUXCO_LTR_C = 3'h2;
    localparam logic [2:0] AUXCO_LTR_U = 3'h3;
    localparam logic [2:0] AUXCO_LTR_V = 3'h4;
    localparam logic [2:0] AUXCO_LTR_W = 3'h5;
    // Reset values
    localparam logic [31:0] AUXCO_CODE_RST = 32'h0000_0000;
    localparam logic AUXCO_STB_RST = 1'b0;

    // Interface variants
    typedef enum logic [1:0] {
        AUXCO_IF_BASE,
        AUXCO_IF_LEGACY_A,
        AUXCO_IF_LEGACY_B
    } auxco_if_t;

    // Handshake state per function
    typedef enum logic [1:0] {
        AUXCO_IDLE,
        AUXCO_WAIT_RISE,
        AUXCO_WAIT_FALL,
        AUXCO_WAIT_LEVEL
    } auxco_hs_t;

    // One code request from the block sequencer
    typedef struct packed {
        logic valid;
        logic [1:0] fn;
        logic [2:0] letter;
        logic neg;
        logic [31:0] mag;
        logic [3:0] digits;
    } auxco_req_t;

    // Per-function limits: digit count and sign permission
    typedef struct packed {
        logic [3:0] max_digits;
        logic allow_neg;
    } auxco_lim_t;

    // Decoded miscellaneous discretes
    typedef struct packed {
        logic stop;
        logic opt_stop;
        logic end_prog;
        logic end_rwd;
    } auxco_mdec_t;
endpackage

//--- testbench/auxco_mside.sv
/*
 Machine-side controller model: answers code strobes with completion.
 Assumes the design's strobes and busy flags change just after sys_clk rises.
*/
`timescale 1ns/10ps
module auxco_mside
    import auxco_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [AUXCO_NFN-1:0] fn_strobe,
    input wire logic [AUXCO_NFN-1:0] fn_busy,
    input wire logic high_speed_active,
    input wire logic [7:0] lag,
    output logic operation_done_in,
    output logic [AUXCO_NFN-1:0] fn_done_in
);
    // Shared done: one rise and fall per busy spell, after a lag
    initial begin
        operation_done_in = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (!rst && !high_speed_active && (|fn_busy)) begin
                repeat (lag) @(posedge sys_clk);
                operation_done_in <= 1'b1;
                repeat (lag + 1) @(posedge sys_clk);
                operation_done_in <= 1'b0;
                // Busy needs a cycle to clear; avoid a second spell
                repeat (2) @(posedge sys_clk);
            end
        end
    end

    // Per-function done follows each strobe level after the lag
    for (genvar i = 0; i < AUXCO_NFN; i++) begin : g_echo
        initial begin
            fn_done_in[i] = 1'b0;
            forever begin
                @(posedge sys_clk);
                if (!rst && high_speed_active && fn_done_in[i] !== fn_strobe[i]) begin
                    repeat (lag) @(posedge sys_clk);
                    fn_done_in[i] <= fn_strobe[i];
                end
            end
        end
    end
endmodule

//--- testbench/test_aux_code_output_handshake.sv
/*
 Self-checking bench for the auxiliary code output block.
 Assumes the machine-side model answers on the completion inputs.
*/
`timescale 1ns/10ps
module test_aux_code_output_handshake
    import auxco_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    auxco_req_t req = '0;
    auxco_lim_t [AUXCO_NFN-1:0] limits = {4{5'h11}};
    logic high_speed_sel = 1'b0;
    auxco_if_t if_variant = AUXCO_IF_BASE;
    logic [5:0] axis_letter_used = 6'h00;
    logic [7:0] lag = 8'h02;
    logic operation_done_in, req_ready, req_reject, misc_code_strobe, high_speed_active;
    logic [AUXCO_NFN-1:0] fn_done_in, fn_strobe, fn_busy;
    logic [31:0] misc_code, spindle_code, tool_code, second_code;
    auxco_mdec_t misc_decode;
    int fails = 0;
    int n_tests = 0;

    // 100 ns clock
    always #50 sys_clk = ~sys_clk;

    auxco_out DUT (.sys_clk(sys_clk), .rst(rst), .req(req), .limits(limits),
        .high_speed_sel(high_speed_sel), .if_variant(if_variant),
        .axis_letter_used(axis_letter_used), .operation_done_in(operation_done_in),
        .fn_done_in(fn_done_in), .req_ready(req_ready), .req_reject(req_reject),
        .misc_code(misc_code), .spindle_code(spindle_code), .tool_code(tool_code),
        .second_code(second_code), .misc_code_strobe(misc_code_strobe),
        .fn_strobe(fn_strobe), .misc_decode(misc_decode), .fn_busy(fn_busy),
        .high_speed_active(high_speed_active));

    auxco_mside MSIDE (.sys_clk(sys_clk), .rst(rst), .fn_strobe(fn_strobe),
        .fn_busy(fn_busy), .high_speed_active(high_speed_active), .lag(lag),
        .operation_done_in(operation_done_in), .fn_done_in(fn_done_in));

    // Verdict and end of run
    task automatic report_and_stop;
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One request, taken at the next edge; sampled once settled
    task automatic send(input logic [1:0] f, input logic n, input logic [31:0] m,
        input logic [3:0] d, input logic [2:0] l);
        @(posedge sys_clk);
        req <= '{1'b1, f, l, n, m, d};
        @(posedge sys_clk);
        req.valid <= 1'b0;
        #1;
    endtask

    // Bounded wait for a function's handshake to finish
    task automatic wait_idle(input int f);
        int k;
        k = 0;
        while (fn_busy[f] !== 1'b0 && k < 200) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        chk({31'h0, fn_busy[f]}, 32'h0);
    endtask

    function automatic logic [31:0] word_of(input int f);
        case (f)
            0: return misc_code;
            1: return spindle_code;
            2: return tool_code;
            default: return second_code;
        endcase
    endfunction

    // Stop/end codes and a plain code, each through a full handshake
    task automatic t_decode;
        logic [31:0] codes [5] = '{32'h0, 32'h1, 32'h2, 32'h1E, 32'hA};
        logic [3:0] dec [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0};
        for (int i = 0; i < 5; i++) begin
            send(2'h0, 1'b0, codes[i], 4'h2, AUXCO_LTR_B);
            chk(misc_code, codes[i]);
            chk({28'h0, misc_decode}, {28'h0, dec[i]});
            chk({31'h0, misc_code_strobe}, 32'h1);
            wait_idle(0);
            chk({31'h0, misc_code_strobe}, 32'h0);
        end
    endtask

    // Negative words on every function
    task automatic t_words;
        for (int f = 0; f < AUXCO_NFN; f++) begin
            send(2'(f), 1'b1, 32'h00BC614E, 4'h8, AUXCO_LTR_C);
            chk(word_of(f), 32'hFF439EB2);
            chk({31'h0, fn_strobe[f]}, 32'h1);
            wait_idle(f);
        end
    endtask

    // Subprogram call and return stay internal
    task automatic t_sub;
        send(2'h0, 1'b0, 32'h62, 4'h2, AUXCO_LTR_B);
        send(2'h0, 1'b0, 32'h63, 4'h2, AUXCO_LTR_B);
        chk(misc_code, 32'h0000000A);
        chk({30'h0, fn_strobe[0], fn_busy[0]}, 32'h0);
    endtask

    // Same function stalled while busy, req_ready low; another function overlaps
    task automatic t_busy;
        lag <= 8'h14;
        send(2'h0, 1'b0, 32'h5, 4'h1, AUXCO_LTR_B);
        send(2'h0, 1'b0, 32'h7, 4'h1, AUXCO_LTR_B);
        chk({31'h0, req_ready}, 32'h0);
        chk(misc_code, 32'h5);
        send(2'h2, 1'b0, 32'h9, 4'h1, AUXCO_LTR_B);
        chk(tool_code, 32'h9);
        wait_idle(0);
        wait_idle(2);
        lag <= 8'h02;
    endtask

    // Digit count and sign limits, then the second code letter
    task automatic t_limits;
        limits[0].max_digits <= 4'h3;
        send(2'h0, 1'b0, 32'h4D2, 4'h4, AUXCO_LTR_B);
        chk({31'h0, req_reject}, 32'h1);
        limits <= {4{5'h10}};
        send(2'h0, 1'b1, 32'h5, 4'h1, AUXCO_LTR_B);
        chk({31'h0, req_reject}, 32'h1);
        chk(misc_code, 32'h5);
        limits <= {4{5'h11}};
        axis_letter_used <= 6'h02;
        send(2'h3, 1'b0, 32'h3, 4'h1, AUXCO_LTR_A);
        chk({31'h0, req_reject}, 32'h1);
        send(2'h3, 1'b0, 32'h4, 4'h1, AUXCO_LTR_U);
        chk(second_code, 32'h4);
        chk({31'h0, req_reject}, 32'h0);
        wait_idle(3);
    endtask

    // Toggle scheme on the base interface, refused on a legacy one
    task automatic t_fast;
        logic s;
        @(posedge sys_clk);
        high_speed_sel <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({31'h0, high_speed_active}, 32'h1);
        for (int i = 0; i < 2; i++) begin
            s = fn_strobe[2];
            send(2'h2, 1'b0, 32'h10 + i, 4'h2, AUXCO_LTR_B);
            chk({31'h0, fn_strobe[2]}, {31'h0, ~s});
            wait_idle(2);
            chk({31'h0, operation_done_in}, 32'h0);
            chk({31'h0, fn_strobe[2]}, {31'h0, ~s});
        end
        if_variant <= AUXCO_IF_LEGACY_A;
        repeat (2) @(posedge sys_clk);
        #1;
        chk({31'h0, high_speed_active}, 32'h0);
        send(2'h0, 1'b0, 32'h8, 4'h1, AUXCO_LTR_B);
        chk({31'h0, misc_code_strobe}, 32'h1);
        wait_idle(0);
        high_speed_sel <= 1'b0;
        if_variant <= AUXCO_IF_BASE;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk({31'h0, req_ready}, 32'h1);
        chk(misc_code, 32'h0);
        t_decode();
        t_sub();
        t_words();
        t_busy();
        t_limits();
        t_fast();
        report_and_stop();
    end

    // Watchdog, far beyond the expected run
    initial begin
        #1000000;
        fails++;
        report_and_stop();
    end
endmodule
